// [inc/mode_cfg_defs.vh]
// constants for the burst and latency mode register block
`ifndef MODE_CFG_DEFS_VH
`define MODE_CFG_DEFS_VH
`define ADDR_BURST_CFG   8'h01
`define ADDR_LATENCY_CFG 8'h02
`define BURST_CFG_RST    8'h22
`define LATENCY_CFG_RST  8'h01
`define LEN_LSB          0
`define LEN_MSB          2
`define ORDER_BIT        3
`define WRAP_BIT         4
`define WR_LSB           5
`define WR_MSB           7
`define LAT_LSB          0
`define LAT_MSB          3
`define LEN4_CODE        3'h2
`define LEN8_CODE        3'h3
`define LEN16_CODE       3'h4
`define WR_CODE_MIN      3'h1
`define WR_CODE_MAX      3'h6
`define WR_CODE_OFFSET   4'h2
`define LAT_CODE_MIN     4'h1
`define LAT_CODE_MAX     4'h6
`define LAT_CODE_4_2     4'h2
`define LAT_CODE_5_2     4'h3
`define LAT_CODE_6_3     4'h4
`define LAT_CODE_7_4     4'h5
`define LAT_CODE_8_4     4'h6
`define RD_LAT_3         4'h3
`define RD_LAT_4         4'h4
`define RD_LAT_5         4'h5
`define RD_LAT_6         4'h6
`define RD_LAT_7         4'h7
`define RD_LAT_8         4'h8
`define WR_LAT_1         3'h1
`define WR_LAT_2         3'h2
`define WR_LAT_3         3'h3
`define WR_LAT_4         3'h4
`define BEATS_4          5'h04
`define BEATS_8          5'h08
`define BEATS_16         5'h10
`define MASK_4           4'h3
`define MASK_8           4'h7
`define MASK_16          4'hf
`endif

// [hw/burst_col_gen.v]
// column address generator for one burst beat
`timescale 1ns/1ns
`include "mode_cfg_defs.vh"
module burst_col_gen #(
  parameter COL_W = 11
) (
  input  wire [COL_W-1:0] start_col,
  input  wire [3:0]       beat_idx,
  input  wire [3:0]       ord_mask,
  input  wire             interleave,
  input  wire             no_wrap,
  output reg  [COL_W-1:0] beat_col
);
  reg [3:0]       low_d;
  reg [COL_W-1:0] base_even;

  always @*
  begin
    base_even = {start_col[COL_W-1:1], 1'b0};
    if (interleave)
      low_d = base_even[3:0] ^ beat_idx;
    else
      low_d = base_even[3:0] + beat_idx;
    if (no_wrap)
      beat_col = base_even + {{(COL_W-4){1'b0}}, beat_idx};
    else
      beat_col = (base_even & ~{{(COL_W-4){1'b0}}, ord_mask}) |
                 {{(COL_W-4){1'b0}}, low_d & ord_mask};
  end
endmodule // burst_col_gen

// [hw/wr_recovery_timer.v]
// write recovery countdown before internal precharge
`timescale 1ns/1ns
module wr_recovery_timer (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire [3:0] cycles,
  output wire       busy,
  output reg        precharge_start
);
  reg [3:0] cnt_q;
  reg       run_q;

  assign busy = run_q;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q           <= 4'h0;
      run_q           <= 1'b0;
      precharge_start <= 1'b0;
    end
    else
    begin
      precharge_start <= 1'b0;
      if (start)
      begin
        cnt_q <= cycles;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (cnt_q == 4'h1)
        begin
          run_q           <= 1'b0;
          precharge_start <= 1'b1;
        end
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // wr_recovery_timer

// [hw/mode_cfg.v]
// burst and latency mode registers with burst column sequencing
`timescale 1ns/1ns
`include "mode_cfg_defs.vh"
// Functional notes
// - bits 2:0 pick burst length: 4 (default), 8 or 16; rest reserved
// - bit 3 picks sequential (default) or interleaved; interleave xors index
// - wrapped sequential offset is start plus index modulo burst length
// - bit 4 selects wrap or no-wrap; no-wrap only with 4 beats
// - bits 7:5 codes 1..6 give write recovery 3..8 cycles
// - auto-precharge write starts precharge after write recovery cycles
// - lowest column bit is not carried and is taken as zero
// - wrapped ordering uses column bits 1:0, 2:0 or 3:0; higher bits fixed
// - no-wrap 4 beats gives y, y+1, y+2, y+3 without wrapping
// - latency register sits at mode address 02h
// - latency bits 3:0 codes 1..6 give read/write latency pairs
// - burst register sits at mode address 01h, written by write command
// - read of write-only register toggles strobe, data undefined
module mode_cfg #(
  parameter COL_W = 11
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             mode_reg_write_cmd,
  input  wire             mode_reg_read_cmd,
  input  wire [7:0]       mode_reg_addr,
  input  wire [7:0]       opcode_bits,
  input  wire             burst_start,
  input  wire             burst_is_write,
  input  wire             auto_precharge,
  input  wire [COL_W-1:0] burst_col,
  output reg              read_strobe,
  output reg  [7:0]       read_data,
  output reg              beat_valid,
  output reg  [COL_W-1:0] beat_col,
  output reg              beat_last,
  output wire             burst_busy,
  output wire             precharge_start,
  output wire             wr_recovery_busy,
  output wire [4:0]       burst_beats,
  output wire             burst_order_sel,
  output wire             wrap_ctl,
  output wire [3:0]       write_recovery_cycles,
  output wire [3:0]       read_latency,
  output wire [2:0]       write_latency,
  output wire             cfg_reserved
);
  reg        rst_s1_q;
  reg        rst_n_q;
  reg  [7:0] burst_config_q;
  reg  [7:0] latency_config_q;
  reg        busy_q;
  reg  [3:0] beat_q;
  reg  [3:0] last_q;
  reg  [3:0] mask_q;
  reg        ilv_q;
  reg        nowrap_q;
  reg        pc_arm_q;
  reg  [3:0] wr_cyc_q;
  reg  [COL_W-1:0] col_q;
  reg  [4:0] beats_d;
  reg  [3:0] mask_d;
  reg  [3:0] rd_lat_d;
  reg  [2:0] wr_lat_d;
  wire [2:0] burst_len_sel;
  wire [2:0] wr_code;
  wire [3:0] lat_code;
  wire [COL_W-1:0] gen_col;
  wire       bl_ok;
  wire       wr_ok;
  wire       lat_ok;
  wire       nw_ok;
  wire       done;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      burst_config_q   <= `BURST_CFG_RST;
      latency_config_q <= `LATENCY_CFG_RST;
    end
    else if (mode_reg_write_cmd)
    begin
      if (mode_reg_addr == `ADDR_BURST_CFG)
        burst_config_q <= opcode_bits;
      else if (mode_reg_addr == `ADDR_LATENCY_CFG)
        latency_config_q <= opcode_bits;
    end
  end

  assign burst_len_sel   = burst_config_q[`LEN_MSB:`LEN_LSB];
  assign burst_order_sel = burst_config_q[`ORDER_BIT];
  assign wrap_ctl        = burst_config_q[`WRAP_BIT];
  assign wr_code         = burst_config_q[`WR_MSB:`WR_LSB];
  assign lat_code        = latency_config_q[`LAT_MSB:`LAT_LSB];

  always @*
  begin
    case (burst_len_sel)
      `LEN8_CODE:
      begin
        beats_d = `BEATS_8;
        mask_d  = `MASK_8;
      end
      `LEN16_CODE:
      begin
        beats_d = `BEATS_16;
        mask_d  = `MASK_16;
      end
      default:
      begin
        beats_d = `BEATS_4;
        mask_d  = `MASK_4;
      end
    endcase
    case (lat_code)
      `LAT_CODE_4_2:
      begin
        rd_lat_d = `RD_LAT_4;
        wr_lat_d = `WR_LAT_2;
      end
      `LAT_CODE_5_2:
      begin
        rd_lat_d = `RD_LAT_5;
        wr_lat_d = `WR_LAT_2;
      end
      `LAT_CODE_6_3:
      begin
        rd_lat_d = `RD_LAT_6;
        wr_lat_d = `WR_LAT_3;
      end
      `LAT_CODE_7_4:
      begin
        rd_lat_d = `RD_LAT_7;
        wr_lat_d = `WR_LAT_4;
      end
      `LAT_CODE_8_4:
      begin
        rd_lat_d = `RD_LAT_8;
        wr_lat_d = `WR_LAT_4;
      end
      default:
      begin
        rd_lat_d = `RD_LAT_3;
        wr_lat_d = `WR_LAT_1;
      end
    endcase
  end

  assign bl_ok  = (burst_len_sel == `LEN4_CODE) ||
                  (burst_len_sel == `LEN8_CODE) ||
                  (burst_len_sel == `LEN16_CODE);
  assign wr_ok  = (wr_code >= `WR_CODE_MIN) && (wr_code <= `WR_CODE_MAX);
  assign lat_ok = (lat_code >= `LAT_CODE_MIN) &&
                  (lat_code <= `LAT_CODE_MAX);
  assign nw_ok  = !wrap_ctl || (burst_len_sel == `LEN4_CODE);
  assign cfg_reserved = !(bl_ok && wr_ok && lat_ok && nw_ok);

  assign burst_beats           = beats_d;
  assign write_recovery_cycles = {1'b0, wr_code} + `WR_CODE_OFFSET;
  assign read_latency          = rd_lat_d;
  assign write_latency         = wr_lat_d;
  assign burst_busy            = busy_q;
  assign done                  = busy_q && (beat_q == last_q);

  // settings latched per burst so later writes leave it alone
  always @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      busy_q   <= 1'b0;
      beat_q   <= 4'h0;
      last_q   <= 4'h0;
      mask_q   <= 4'h0;
      ilv_q    <= 1'b0;
      nowrap_q <= 1'b0;
      pc_arm_q <= 1'b0;
      wr_cyc_q <= 4'h0;
      col_q    <= {COL_W{1'b0}};
    end
    else if (burst_start && !busy_q)
    begin
      busy_q   <= 1'b1;
      beat_q   <= 4'h0;
      last_q   <= beats_d[3:0] - 4'h1;
      mask_q   <= mask_d;
      ilv_q    <= burst_order_sel;
      nowrap_q <= wrap_ctl;
      pc_arm_q <= burst_is_write && auto_precharge;
      wr_cyc_q <= write_recovery_cycles;
      col_q    <= burst_col;
    end
    else if (busy_q)
    begin
      beat_q <= beat_q + 4'h1;
      if (done)
        busy_q <= 1'b0;
    end
  end

  burst_col_gen #(
    .COL_W      (COL_W)
  ) u_col (
    .start_col  (col_q),
    .beat_idx   (beat_q),
    .ord_mask   (mask_q),
    .interleave (ilv_q),
    .no_wrap    (nowrap_q),
    .beat_col   (gen_col)
  );

  always @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      beat_valid  <= 1'b0;
      beat_col    <= {COL_W{1'b0}};
      beat_last   <= 1'b0;
      read_strobe <= 1'b0;
      read_data   <= 8'h00;
    end
    else
    begin
      beat_valid  <= busy_q;
      beat_col    <= busy_q ? gen_col : {COL_W{1'b0}};
      beat_last   <= done;
      read_strobe <= mode_reg_read_cmd;
      read_data   <= 8'h00;
    end
  end

  wr_recovery_timer u_wr (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n_q),
    .start           (done && pc_arm_q),
    .cycles          (wr_cyc_q),
    .busy            (wr_recovery_busy),
    .precharge_start (precharge_start)
  );
endmodule // mode_cfg

// [tb/mem_ctl_model.sv]
// controller model issuing mode commands and bursts
`timescale 1ns/1ns
module mem_ctl_model (
  input wire ref_clk,
  output logic mode_reg_write_cmd, mode_reg_read_cmd, burst_start,
  output logic burst_is_write, auto_precharge,
  output logic [7:0] mode_reg_addr, opcode_bits,
  output logic [10:0] burst_col
);
  initial
    {mode_reg_write_cmd, mode_reg_read_cmd, burst_start, burst_is_write,
      auto_precharge, mode_reg_addr, opcode_bits, burst_col} = 32'h0;
  // one command cycle, released lines show inverted values
  task automatic issue(logic [2:0] kd, logic [7:0] a, d, logic [10:0] c,
    bit w);
    @(posedge ref_clk) #1;
    {mode_reg_write_cmd, mode_reg_read_cmd, burst_start} = kd;
    mode_reg_addr = a;
    opcode_bits = a == 8'h02 ? {4'h0, d[3:0]} : d;
    burst_col = c;
    {burst_is_write, auto_precharge} = {w, w};
    @(posedge ref_clk) #1;
    {mode_reg_write_cmd, mode_reg_read_cmd, burst_start} = 3'h0;
    {mode_reg_addr, opcode_bits, burst_col, burst_is_write,
      auto_precharge} = ~{a, d, c, w, w};
  endtask
endmodule // mem_ctl_model

// [tb/mode_cfg_chk.sv]
// port assertions for the mode register block
`timescale 1ns/1ns
module mode_cfg_chk #(
  parameter COL_W = 11
) (
  input wire ref_clk, nrst, mode_reg_write_cmd, mode_reg_read_cmd,
  input wire burst_start, read_strobe, beat_valid, beat_last, burst_busy,
  input wire wrap_ctl, burst_order_sel,
  input wire [7:0] mode_reg_addr, opcode_bits,
  input wire [COL_W-1:0] burst_col, beat_col,
  input wire [4:0] burst_beats,
  input wire [3:0] write_recovery_cycles, read_latency,
  input wire [2:0] write_latency
);
  wire w1 = mode_reg_write_cmd && mode_reg_addr == 8'h01;
  wire w2 = mode_reg_write_cmd && mode_reg_addr == 8'h02;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_RD_STROBE: assert property (
    mode_reg_read_cmd |=> read_strobe) else $error("no strobe");
  AST_MODE_BITS: assert property (
    w1 |=> {wrap_ctl, burst_order_sel} == $past(opcode_bits[4:3]))
    else $error("mode bits");
  AST_WR_REC: assert property (
    w1 && opcode_bits[7:5] inside {[3'h1:3'h6]} |=> write_recovery_cycles
    == $past(opcode_bits[7:5]) + 4'h2) else $error("recovery");
  AST_BL16: assert property (
    w1 && opcode_bits[2:0] == 3'h4 |=> burst_beats == 5'h10)
    else $error("length");
  AST_LAT: assert property (
    w2 && opcode_bits[3:0] == 4'h6 |=> read_latency == 4'h8 &&
    write_latency == 3'h4) else $error("latency");
  AST_KEEP: assert property (
    mode_reg_write_cmd && mode_reg_addr > 8'h02 |=> $stable(read_latency)
    && $stable(burst_beats)) else $error("stray write");
  AST_COL0: assert property (
    burst_start && !burst_busy |-> ##2 beat_valid &&
    beat_col == {$past(burst_col[COL_W-1:1], 2), 1'b0}) else $error("col");
  AST_HIGH: assert property (
    beat_valid && !beat_last && !wrap_ctl |=> beat_valid &&
    beat_col[COL_W-1:4] == $past(beat_col[COL_W-1:4])) else $error("high");
endmodule // mode_cfg_chk
bind mode_cfg mode_cfg_chk #(.COL_W(COL_W)) u_chk (.*);

// [tb/test_burst_latency_mode_config.sv]
// self-checking bench for the mode register block
`timescale 1ns/1ns
module test_burst_latency_mode_config;
  logic ref_clk, nrst, mode_reg_write_cmd, mode_reg_read_cmd, burst_start;
  logic burst_is_write, auto_precharge, read_strobe, beat_valid, beat_last;
  logic burst_busy, precharge_start, wr_recovery_busy, burst_order_sel;
  logic wrap_ctl, cfg_reserved;
  logic [7:0] mode_reg_addr, opcode_bits, read_data;
  logic [10:0] burst_col, beat_col;
  logic [4:0] burst_beats;
  logic [3:0] write_recovery_cycles, read_latency;
  logic [2:0] write_latency;
  int fail_count, check_count, k;
  localparam logic [47:0] LAT_T = 48'h443c332a2219;
  mem_ctl_model ctl (.*);
  mode_cfg DUT (.*);
  task automatic chk(string n, logic [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    ctl.issue(3'h4, a, d, 11'h0, 1'b0);
  endtask
  task automatic t_regs;
    chk("cfg", {burst_order_sel, wrap_ctl, cfg_reserved}, 3'h0);
    chk("len", {burst_beats, write_recovery_cycles}, 9'h043);
    chk("lat", {read_latency, write_latency}, 7'h19);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h01, {3'(i + 1), 2'h0, 3'(2 + i % 3)});
      chk("bl", burst_beats, 5'h4 << i % 3);
      chk("nwr", write_recovery_cycles, 16'(i + 3));
      wr(8'h02, 8'(i + 1));
      chk("lat", {read_latency, write_latency}, LAT_T[8*i+:7]);
    end
    wr(8'h03, 8'h05);
    chk("keep", {burst_beats, read_latency}, 9'h108);
    wr(8'h01, 8'h33);
    chk("rsv", cfg_reserved, 1'b1);
    ctl.issue(3'h2, 8'h01, 8'h00, 11'h0, 1'b0);
    chk("rd", {read_strobe, read_data}, 9'h100);
  endtask
  task automatic t_burst(logic [10:0] c, int n, bit x, nw, pc_on);
    logic [10:0] m, s, e;
    m = 11'(n - 1);
    s = {c[10:1], 1'b0};
    wr(8'h01, {3'h3, nw, x, (n == 4 ? 3'h2 : n == 8 ? 3'h3 : 3'h4)});
    chk("mode", {burst_order_sel, wrap_ctl}, {x, nw});
    ctl.issue(3'h1, 8'h00, 8'h00, c, pc_on);
    for (k = 0; beat_valid !== 1'b1 && k < 8; k++)
      @(posedge ref_clk) #1;
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        @(posedge ref_clk) #1;
      e = x ? s ^ 11'(i) : s + 11'(i);
      chk("col", beat_col, nw ? s + 11'(i) : s & ~m | e & m);
      chk("last", beat_last, i == n - 1);
      chk("busy", {beat_valid, burst_busy}, {1'b1, i != n - 1});
    end
    chk("wrb", wr_recovery_busy, pc_on);
    for (k = 0; precharge_start !== 1'b1 && k < 20; k++)
      @(posedge ref_clk) #1;
    chk("pc", k, pc_on ? 5 : 20);
  endtask
  task automatic t_reset;
    nrst = 1'b0;
    @(posedge ref_clk) #1;
    chk("rst", {beat_valid, read_strobe, precharge_start}, 3'h0);
    nrst = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    chk("dflt", {burst_beats, write_recovery_cycles, wrap_ctl}, 10'h086);
    chk("dlat", {read_latency, write_latency}, 7'h19);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #20000;
    fail_count++;
    test_done;
  end
  initial
  begin
    nrst = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    t_regs;
    t_burst(11'h006, 4, 0, 0, 0);
    t_burst(11'h7f7, 8, 1, 0, 0);
    t_burst(11'h01a, 16, 0, 0, 0);
    t_burst(11'h00e, 4, 0, 1, 1);
    t_reset;
    test_done;
  end
endmodule // test_burst_latency_mode_config
